// ### rtl/sqc_defs.vh
// constants for the transceiver quad control register bank
`ifndef SQC_DEFS_VH
`define SQC_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SQC_IDX_W          18
`define SQC_IDX_CH_A       18'h30004
`define SQC_IDX_TEST_SEL   18'h30006
`define SQC_IDX_CH_B       18'h30014
`define SQC_IDX_CH_C       18'h30024
`define SQC_IDX_CH_D       18'h30034
`define SQC_IDX_QUAD_CTRL  18'h30007
`define SQC_IDX_INT_STAT   18'h30008
`define SQC_IDX_INT_MASK   18'h30009
`define SQC_ADDR_W         20

// ----------------------------------------------------------------
// field positions on the data bus (bit 0 of a register is the lsb)
// ----------------------------------------------------------------
`define SQC_CH_ALARM_MASK  6
`define SQC_CH_SOFT_RESET  5
`define SQC_CH_TEST_EN     0
`define SQC_Q_ALARM_MASK   6
`define SQC_Q_SOFT_RESET   5
`define SQC_Q_TX_PD        4
`define SQC_Q_RX_PD        3
`define SQC_Q_RSVD_ONE     2
`define SQC_Q_TEST_EN      0
`define SQC_TSEL_HI        7
`define SQC_TSEL_LO        3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SQC_RST_CH         8'h40
`define SQC_RST_QUAD       8'h44
`define SQC_RST_TSEL       5'h00
`define SQC_RST_INT_MASK   8'h00

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define SQC_RESP_OKAY      2'h0
`define SQC_RESP_DECERR    2'h3

`endif

// ### rtl/sqc_ctrl_regs.v
// control register bank of one four-channel transceiver quad, axi4-lite slave
`timescale 1ns/1ns
`default_nettype none
`include "sqc_defs.vh"

// What this block does
// - channel alarm mask blocks its alarm interrupts
// - channel mask overrides individual alarm masks
// - channel soft reset holds datapath, keeps config
// - soft reset bits never self-clear
// - channel test enable puts channel in test
// - quad test enable forces all channels test
// - quad alarm mask blocks every channel alarm
// - quad soft reset resets all four channels
// - quad tx powerdown overrides channel tx bits
// - quad rx powerdown overrides channel rx bits
// - reset loads 0x40 per channel, 0x44 quad
// - five-bit test select, cleared at reset
// - one quad register acts on all channels
module sqc_ctrl_regs #(
  parameter NCH = 4
) (
  input  wire                     core_clk,
  input  wire                     nrst,
  input  wire [`SQC_ADDR_W-1:0]   s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  output wire [1:0]               s_axi_bresp,
  output wire                     s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`SQC_ADDR_W-1:0]   s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  output wire [31:0]              s_axi_rdata,
  output wire [1:0]               s_axi_rresp,
  output wire                     s_axi_rvalid,
  input  wire                     s_axi_rready,
  input  wire [NCH-1:0]           txAlarm,
  input  wire [NCH-1:0]           rxAlarm,
  input  wire [NCH-1:0]           txAlarmIndivMask,
  input  wire [NCH-1:0]           rxAlarmIndivMask,
  input  wire [NCH-1:0]           channelTxPowerdown,
  input  wire [NCH-1:0]           channelRxPowerdown,
  output wire [NCH-1:0]           chTxReset,
  output wire [NCH-1:0]           chRxReset,
  output wire [NCH-1:0]           chTestMode,
  output wire [4:0]               testSelect,
  output wire [NCH-1:0]           chTxPowerdown,
  output wire [NCH-1:0]           chRxPowerdown,
  output wire                     irq
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [NCH-1:0]           chAlarmMask_q;
  reg  [NCH-1:0]           chSoftReset_q;
  reg  [NCH-1:0]           chTestEn_q;
  reg                      quadAlarmMask_q;
  reg                      quadSoftReset_q;
  reg                      quadTxPd_q;
  reg                      quadRxPd_q;
  reg                      quadTestEn_q;
  reg  [4:0]               testSel_q;
  reg  [2*NCH-1:0]         intStat_q;
  reg  [2*NCH-1:0]         intMask_q;

  // ----------------------------------------------------------------
  // bus channel state
  // ----------------------------------------------------------------
  reg                      awHave_q;
  reg                      wHave_q;
  reg  [`SQC_IDX_W-1:0]    wrIdx_q;
  reg  [7:0]               wrData_q;
  reg                      wrLane0_q;
  reg                      bValid_q;
  reg  [1:0]               bResp_q;
  reg                      rValid_q;
  reg  [31:0]              rData_q;
  reg  [1:0]               rResp_q;
  reg  [NCH-1:0]           chTxReset_q;
  reg  [NCH-1:0]           chRxReset_q;
  reg  [NCH-1:0]           chTestMode_q;
  reg  [NCH-1:0]           chTxPd_q;
  reg  [NCH-1:0]           chRxPd_q;
  reg                      irq_q;

  wire                     awTake = s_axi_awvalid & ~awHave_q & ~bValid_q;
  wire                     wTake  = s_axi_wvalid & ~wHave_q & ~bValid_q;
  wire                     doWr   = awHave_q & wHave_q & ~bValid_q;
  wire                     arTake = s_axi_arvalid & ~rValid_q;
  wire [`SQC_IDX_W-1:0]    rdIdx  = s_axi_araddr[`SQC_ADDR_W-1:2];

  // ----------------------------------------------------------------
  // next state of the handshake flags
  // ----------------------------------------------------------------
  // ready lines are registered copies of the next flag state, so every
  // bus output comes from a flop and no handshake cycle is lost
  reg                      awHave_d;
  reg                      wHave_d;
  reg                      bValid_d;
  reg                      rValid_d;
  reg                      awReady_q;
  reg                      wReady_q;
  reg                      arReady_q;

  always @* begin
    awHave_d = awHave_q;
    wHave_d  = wHave_q;
    bValid_d = bValid_q;
    rValid_d = rValid_q;
    if (awTake) begin
      awHave_d = 1'b1;
    end
    if (wTake) begin
      wHave_d = 1'b1;
    end
    if (doWr) begin
      awHave_d = 1'b0;
      wHave_d  = 1'b0;
      bValid_d = 1'b1;
    end else if (bValid_q && s_axi_bready) begin
      bValid_d = 1'b0;
    end
    if (arTake) begin
      rValid_d = 1'b1;
    end else if (rValid_q && s_axi_rready) begin
      rValid_d = 1'b0;
    end
  end

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awReady_q <= 1'b1;
      wReady_q  <= 1'b1;
      arReady_q <= 1'b1;
    end else begin
      awReady_q <= ~awHave_d & ~bValid_d;
      wReady_q  <= ~wHave_d & ~bValid_d;
      arReady_q <= ~rValid_d;
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function [`SQC_IDX_W-1:0] chIdx;
    input integer ch;
    begin
      case (ch)
        0:       chIdx = `SQC_IDX_CH_A;
        1:       chIdx = `SQC_IDX_CH_B;
        2:       chIdx = `SQC_IDX_CH_C;
        default: chIdx = `SQC_IDX_CH_D;
      endcase
    end
  endfunction

  // write strobes, only byte lane 0 carries register bits
  wire                     wrOk    = doWr & wrLane0_q;
  wire                     wrQuad  = wrOk & (wrIdx_q == `SQC_IDX_QUAD_CTRL);
  wire                     wrTsel  = wrOk & (wrIdx_q == `SQC_IDX_TEST_SEL);
  wire                     wrIstat = wrOk & (wrIdx_q == `SQC_IDX_INT_STAT);
  wire                     wrImask = wrOk & (wrIdx_q == `SQC_IDX_INT_MASK);
  reg                      wrHit;
  reg                      rdHit;
  reg  [7:0]               rdByte;
  integer                  i;

  // ----------------------------------------------------------------
  // read mux and write hit
  // ----------------------------------------------------------------
  always @* begin
    wrHit  = (wrIdx_q == `SQC_IDX_QUAD_CTRL) | (wrIdx_q == `SQC_IDX_TEST_SEL)
           | (wrIdx_q == `SQC_IDX_INT_STAT) | (wrIdx_q == `SQC_IDX_INT_MASK);
    rdHit  = 1'b1;
    rdByte = 8'h00;
    for (i = 0; i < NCH; i = i + 1) begin
      if (wrIdx_q == chIdx(i)) begin
        wrHit = 1'b1;
      end
    end
    // reserved bits read zero, except the quad reserved bit, which always reads one
    case (rdIdx)
      `SQC_IDX_QUAD_CTRL: begin
        rdByte[`SQC_Q_ALARM_MASK] = quadAlarmMask_q;
        rdByte[`SQC_Q_SOFT_RESET] = quadSoftReset_q;
        rdByte[`SQC_Q_TX_PD]      = quadTxPd_q;
        rdByte[`SQC_Q_RX_PD]      = quadRxPd_q;
        rdByte[`SQC_Q_RSVD_ONE]   = 1'b1;
        rdByte[`SQC_Q_TEST_EN]    = quadTestEn_q;
      end
      `SQC_IDX_TEST_SEL: begin
        rdByte[`SQC_TSEL_HI:`SQC_TSEL_LO] = testSel_q;
      end
      `SQC_IDX_INT_STAT: begin
        rdByte = intStat_q;
      end
      `SQC_IDX_INT_MASK: begin
        rdByte = intMask_q;
      end
      default: begin
        rdHit = 1'b0;
        for (i = 0; i < NCH; i = i + 1) begin
          if (rdIdx == chIdx(i)) begin
            rdHit = 1'b1;
            rdByte[`SQC_CH_ALARM_MASK] = chAlarmMask_q[i];
            rdByte[`SQC_CH_SOFT_RESET] = chSoftReset_q[i];
            rdByte[`SQC_CH_TEST_EN]    = chTestEn_q[i];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // axi4-lite write and read channels
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awHave_q  <= 1'b0;
      wHave_q   <= 1'b0;
      wrIdx_q   <= {`SQC_IDX_W{1'b0}};
      wrData_q  <= 8'h00;
      wrLane0_q <= 1'b0;
      bValid_q  <= 1'b0;
      bResp_q   <= `SQC_RESP_OKAY;
      rValid_q  <= 1'b0;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= `SQC_RESP_OKAY;
    end else begin
      if (awTake) begin
        awHave_q <= 1'b1;
        wrIdx_q  <= s_axi_awaddr[`SQC_ADDR_W-1:2];
      end
      if (wTake) begin
        wHave_q   <= 1'b1;
        wrData_q  <= s_axi_wdata[7:0];
        wrLane0_q <= s_axi_wstrb[0];
      end
      if (doWr) begin
        awHave_q <= 1'b0;
        wHave_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrHit ? `SQC_RESP_OKAY : `SQC_RESP_DECERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
      if (arTake) begin
        rValid_q <= 1'b1;
        rData_q  <= {24'h000000, rdByte};
        rResp_q  <= rdHit ? `SQC_RESP_OKAY : `SQC_RESP_DECERR;
      end else if (rValid_q && s_axi_rready) begin
        rValid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // quad-wide registers
  // ----------------------------------------------------------------
  // soft reset bits hold whatever was written; only nrst clears them
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      quadAlarmMask_q <= 1'b1;
      quadSoftReset_q <= 1'b0;
      quadTxPd_q      <= 1'b0;
      quadRxPd_q      <= 1'b0;
      quadTestEn_q    <= 1'b0;
      testSel_q       <= `SQC_RST_TSEL;
      intMask_q       <= `SQC_RST_INT_MASK;
    end else begin
      if (wrQuad) begin
        quadAlarmMask_q <= wrData_q[`SQC_Q_ALARM_MASK];
        quadSoftReset_q <= wrData_q[`SQC_Q_SOFT_RESET];
        quadTxPd_q      <= wrData_q[`SQC_Q_TX_PD];
        quadRxPd_q      <= wrData_q[`SQC_Q_RX_PD];
        quadTestEn_q    <= wrData_q[`SQC_Q_TEST_EN];
      end
      if (wrTsel) begin
        testSel_q <= wrData_q[`SQC_TSEL_HI:`SQC_TSEL_LO];
      end
      if (wrImask) begin
        intMask_q <= wrData_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-channel registers and controls
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gCh
      wire wrCh = wrOk & (wrIdx_q == chIdx(g));
      // the individual mask inputs cannot unblock once a channel or quad mask is set
      wire txBlock = quadAlarmMask_q | chAlarmMask_q[g] | txAlarmIndivMask[g];
      wire rxBlock = quadAlarmMask_q | chAlarmMask_q[g] | rxAlarmIndivMask[g];

      always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          chAlarmMask_q[g] <= 1'b1;
          chSoftReset_q[g] <= 1'b0;
          chTestEn_q[g]    <= 1'b0;
          chTxReset_q[g]   <= 1'b1;
          chRxReset_q[g]   <= 1'b1;
          chTestMode_q[g]  <= 1'b0;
          chTxPd_q[g]      <= 1'b0;
          chRxPd_q[g]      <= 1'b0;
          intStat_q[g]     <= 1'b0;
          intStat_q[g+NCH] <= 1'b0;
        end else begin
          if (wrCh) begin
            // reserved msb is not stored, so a stray one is harmless
            chAlarmMask_q[g] <= wrData_q[`SQC_CH_ALARM_MASK];
            chSoftReset_q[g] <= wrData_q[`SQC_CH_SOFT_RESET];
            chTestEn_q[g]    <= wrData_q[`SQC_CH_TEST_EN];
          end
          // datapath reset only; no configuration flop listens to it
          chTxReset_q[g]  <= quadSoftReset_q | chSoftReset_q[g];
          chRxReset_q[g]  <= quadSoftReset_q | chSoftReset_q[g];
          chTestMode_q[g] <= quadTestEn_q | chTestEn_q[g];
          chTxPd_q[g]     <= quadTxPd_q | channelTxPowerdown[g];
          chRxPd_q[g]     <= quadRxPd_q | channelRxPowerdown[g];
          // a new alarm wins over a clear in the same cycle
          if (txAlarm[g] && !txBlock) begin
            intStat_q[g] <= 1'b1;
          end else if (wrIstat && wrData_q[g]) begin
            intStat_q[g] <= 1'b0;
          end
          if (rxAlarm[g] && !rxBlock) begin
            intStat_q[g+NCH] <= 1'b1;
          end else if (wrIstat && wrData_q[g+NCH]) begin
            intStat_q[g+NCH] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(intStat_q & intMask_q);
    end
  end

  assign s_axi_awready = awReady_q;
  assign s_axi_wready  = wReady_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid  = rValid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  assign chTxReset     = chTxReset_q;
  assign chRxReset     = chRxReset_q;
  assign chTestMode    = chTestMode_q;
  assign testSelect    = testSel_q;
  assign chTxPowerdown = chTxPd_q;
  assign chRxPowerdown = chRxPd_q;
  assign irq           = irq_q;

endmodule // sqc_ctrl_regs
`default_nettype wire

// ### tb/sqc_ctrl_regs_asserts.sv
// port assertions for the quad control register bank
`timescale 1ns/1ns
`default_nettype none
module sqc_ctrl_regs_asserts #(
  parameter NCH = 4
) (
  input wire logic           core_clk,
  input wire logic           nrst,
  input wire logic           s_axi_bvalid,
  input wire logic [NCH-1:0] txAlarm,
  input wire logic [NCH-1:0] rxAlarm,
  input wire logic [NCH-1:0] channelTxPowerdown,
  input wire logic [NCH-1:0] channelRxPowerdown,
  input wire logic [NCH-1:0] chTxReset,
  input wire logic [NCH-1:0] chRxReset,
  input wire logic [NCH-1:0] chTestMode,
  input wire logic [4:0]     testSelect,
  input wire logic [NCH-1:0] chTxPowerdown,
  input wire logic [NCH-1:0] chRxPowerdown,
  input wire logic           irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // controls only move with or after a write response
  // ----------------------------------------------------------------
  sequence s_quiet;
    !s_axi_bvalid [*3];
  endsequence
  property p_resetPair;
    chTxReset == chRxReset;
  endproperty
  a_resetPair: assert property (p_resetPair) else $error("tx and rx resets differ");
  property p_resetHold;
    s_quiet |=> $stable(chTxReset);
  endproperty
  a_resetHold: assert property (p_resetHold) else $error("reset moved with no write");
  property p_testHold;
    s_quiet |=> $stable(chTestMode);
  endproperty
  a_testHold: assert property (p_testHold) else $error("test mode moved with no write");
  property p_selHold;
    $changed(testSelect) |-> s_axi_bvalid;
  endproperty
  a_selHold: assert property (p_selHold) else $error("test select moved alone");
  // ----------------------------------------------------------------
  // interrupt cause, powerdown, reset state
  // ----------------------------------------------------------------
  property p_irqCause;
    $rose(irq) |-> $past(|(txAlarm | rxAlarm), 2) || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2);
  endproperty
  a_irqCause: assert property (p_irqCause) else $error("irq rose with no cause");
  property p_txPd;
    |channelTxPowerdown |=> (chTxPowerdown & $past(channelTxPowerdown)) == $past(channelTxPowerdown);
  endproperty
  a_txPd: assert property (p_txPd) else $error("channel tx powerdown lost");
  property p_rxPd;
    |channelRxPowerdown |=> (chRxPowerdown & $past(channelRxPowerdown)) == $past(channelRxPowerdown);
  endproperty
  a_rxPd: assert property (p_rxPd) else $error("channel rx powerdown lost");
  property p_rstState;
    $rose(nrst) |-> chTestMode == '0 && testSelect == 5'h00 && !irq;
  endproperty
  a_rstState: assert property (p_rstState) else $error("bad state after reset");
endmodule // sqc_ctrl_regs_asserts

bind sqc_ctrl_regs sqc_ctrl_regs_asserts #(.NCH(NCH)) sqc_ctrl_regs_asserts_i (
  .core_clk(core_clk), .nrst(nrst), .s_axi_bvalid(s_axi_bvalid), .txAlarm(txAlarm),
  .rxAlarm(rxAlarm), .channelTxPowerdown(channelTxPowerdown),
  .channelRxPowerdown(channelRxPowerdown), .chTxReset(chTxReset), .chRxReset(chRxReset),
  .chTestMode(chTestMode), .testSelect(testSelect), .chTxPowerdown(chTxPowerdown),
  .chRxPowerdown(chRxPowerdown), .irq(irq));
`default_nettype wire

// ### tb/sqc_ctrl_regs_tb.sv
// self-checking bench for the quad control register bank
`timescale 1ns/1ns
`default_nettype none
`include "sqc_defs.vh"
module sqc_ctrl_regs_tb;
  // ----------------------------------------------------------------
  // signals and scoreboard
  // ----------------------------------------------------------------
  logic        core_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready;
  logic [19:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb, txAlarm, rxAlarm, txAlarmIndivMask, rxAlarmIndivMask;
  logic [3:0]  channelTxPowerdown, channelRxPowerdown;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0]  chTxReset, chRxReset, chTestMode, chTxPowerdown, chRxPowerdown;
  wire logic [4:0]  testSelect;
  logic [33:0] expQ [$];
  logic [33:0] got;
  logic [17:0] chIdx [4];
  logic [7:0]  pdQ [4];
  int          numErrors, testsRun, cycles, seed;

  sqc_ctrl_regs #(.NCH(4)) sqc_ctrl_regs_i (
    .core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .txAlarm(txAlarm),
    .rxAlarm(rxAlarm), .txAlarmIndivMask(txAlarmIndivMask),
    .rxAlarmIndivMask(rxAlarmIndivMask), .channelTxPowerdown(channelTxPowerdown),
    .channelRxPowerdown(channelRxPowerdown), .chTxReset(chTxReset), .chRxReset(chRxReset),
    .chTestMode(chTestMode), .testSelect(testSelect), .chTxPowerdown(chTxPowerdown),
    .chRxPowerdown(chRxPowerdown), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    testsRun++;
    if (a !== e) begin
      numErrors++;
      $display("mismatch at %0t: output %h expected %h", $time, a, e);
    end
  endtask

  // ready lines are high when idle, so valid drops at the handshake edge; the write answer comes one edge later
  task automatic wr(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] rsp);
    logic done;
    done = 1'b0;
    expQ.push_back({rsp, 32'h0});
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
    end
  endtask

  task automatic rd(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] rsp);
    logic done;
    done = 1'b0;
    expQ.push_back({rsp, 24'h0, d});
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
    end
  endtask

  task automatic alarm(input logic [3:0] t, input logic [3:0] r);
    txAlarm <= t;
    rxAlarm <= r;
    step(1);
    txAlarm <= 4'h0;
    rxAlarm <= 4'h0;
    step(3);
  endtask

  always @(posedge core_clk) begin
    if (s_axi_rvalid === 1'b1 || s_axi_bvalid === 1'b1) begin
      got = s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0};
      testsRun++;
      if (expQ.size() == 0 || got !== expQ.pop_front()) begin
        numErrors++;
        $display("mismatch at %0t: bus answer %h", $time, got);
      end
    end
  end

  // whole run takes well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      numErrors++;
      tallyAndFinish();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 15825;
    chIdx = '{`SQC_IDX_CH_A, `SQC_IDX_CH_B, `SQC_IDX_CH_C, `SQC_IDX_CH_D};
    pdQ = '{8'h44, 8'h54, 8'h4C, 8'h5C};
    {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 72'h0;
    {txAlarm, rxAlarm, txAlarmIndivMask, rxAlarmIndivMask} = 16'h0;
    {channelTxPowerdown, channelRxPowerdown} = 8'h0;
    step(2);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) rd(chIdx[i], `SQC_RST_CH, `SQC_RESP_OKAY);
    rd(`SQC_IDX_QUAD_CTRL, `SQC_RST_QUAD, `SQC_RESP_OKAY);
    rd(`SQC_IDX_TEST_SEL, 8'h00, `SQC_RESP_OKAY);
    rd(`SQC_IDX_INT_STAT, 8'h00, `SQC_RESP_OKAY);
    rd(`SQC_IDX_INT_MASK, `SQC_RST_INT_MASK, `SQC_RESP_OKAY);
    rd(18'h30005, 8'h00, `SQC_RESP_DECERR);
    wr(18'h3FFFF, 8'hFF, `SQC_RESP_DECERR);
    chk(8'({chRxReset, chTxReset}), 8'h00);
    wr(chIdx[1], 8'h60, `SQC_RESP_OKAY);
    step(6);
    chk(8'({chRxReset, chTxReset}), 8'h22);
    rd(chIdx[1], 8'h60, `SQC_RESP_OKAY);
    wr(chIdx[1], 8'h40, `SQC_RESP_OKAY);
    wr(`SQC_IDX_QUAD_CTRL, 8'h64, `SQC_RESP_OKAY);
    step(1);
    chk(8'({chRxReset, chTxReset}), 8'hFF);
    wr(chIdx[2], 8'h41, `SQC_RESP_OKAY);
    step(1);
    chk(8'(chTestMode), 8'h04);
    wr(`SQC_IDX_QUAD_CTRL, 8'h45, `SQC_RESP_OKAY);
    step(1);
    chk(8'({chTxReset, chTestMode}), 8'h0F);
    wr(`SQC_IDX_QUAD_CTRL, 8'h44, `SQC_RESP_OKAY);
    step(1);
    chk(8'(chTestMode), 8'h04);
    wr(`SQC_IDX_TEST_SEL, 8'hFF, `SQC_RESP_OKAY);
    chk(8'(testSelect), 8'h1F);
    rd(`SQC_IDX_TEST_SEL, 8'hF8, `SQC_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      channelTxPowerdown <= 4'($random(seed));
      channelRxPowerdown <= 4'($random(seed));
      wr(`SQC_IDX_QUAD_CTRL, pdQ[i], `SQC_RESP_OKAY);
      step(1);
      chk(8'(chTxPowerdown), 8'(channelTxPowerdown | {4{pdQ[i][4]}}));
      chk(8'(chRxPowerdown), 8'(channelRxPowerdown | {4{pdQ[i][3]}}));
    end
    wr(`SQC_IDX_INT_MASK, 8'hFF, `SQC_RESP_OKAY);
    alarm(4'h1, 4'h0);
    rd(`SQC_IDX_INT_STAT, 8'h00, `SQC_RESP_OKAY);
    wr(`SQC_IDX_QUAD_CTRL, 8'h04, `SQC_RESP_OKAY);
    alarm(4'h0, 4'h2);
    rd(`SQC_IDX_INT_STAT, 8'h00, `SQC_RESP_OKAY);
    wr(chIdx[0], 8'h00, `SQC_RESP_OKAY);
    txAlarmIndivMask <= 4'h1;
    alarm(4'h1, 4'h0);
    rd(`SQC_IDX_INT_STAT, 8'h00, `SQC_RESP_OKAY);
    txAlarmIndivMask <= 4'h0;
    alarm(4'h1, 4'h0);
    chk(8'(irq), 8'h01);
    rd(`SQC_IDX_INT_STAT, 8'h01, `SQC_RESP_OKAY);
    wr(`SQC_IDX_INT_MASK, 8'h00, `SQC_RESP_OKAY);
    step(1);
    chk(8'(irq), 8'h00);
    wr(`SQC_IDX_INT_MASK, 8'hFF, `SQC_RESP_OKAY);
    wr(`SQC_IDX_INT_STAT, 8'h01, `SQC_RESP_OKAY);
    step(1);
    chk(8'(irq), 8'h00);
    wr(`SQC_IDX_QUAD_CTRL, 8'h44, `SQC_RESP_OKAY);
    alarm(4'h1, 4'h0);
    rd(`SQC_IDX_INT_STAT, 8'h00, `SQC_RESP_OKAY);
    step(2);
    tallyAndFinish();
  end
endmodule // sqc_ctrl_regs_tb
`default_nettype wire
